/* File: lnr_regs.vh */
// register offsets, field positions, reset values and constants of the luma noise reducer
`ifndef LNR_REGS_VH
`define LNR_REGS_VH

// register offsets
`define LNR_OFS_CORING_GAINS 8'ha3
`define LNR_OFS_THRESH_BLOCK 8'ha4
`define LNR_OFS_FILT_MODE 8'ha5

// reset values
`define LNR_RST_CORING_GAINS 8'h00
`define LNR_RST_THRESH_BLOCK 8'h00
`define LNR_RST_FILT_MODE 8'h00

// noise_coring_gains fields
`define LNR_BORDER_GAIN_LSB 0
`define LNR_BORDER_GAIN_MSB 3
`define LNR_DATA_GAIN_LSB 4
`define LNR_DATA_GAIN_MSB 7

// noise_threshold_block_cfg fields
`define LNR_LIMIT_LSB 0
`define LNR_LIMIT_MSB 5
`define LNR_BORDER_WIDE_BIT 6
`define LNR_BLOCK_LARGE_BIT 7

// noise_filter_mode_offset fields (mode bit sits inside the shift field)
`define LNR_FILT_SEL_LSB 0
`define LNR_FILT_SEL_MSB 2
`define LNR_MODE_BIT 4
`define LNR_SHIFT_LSB 4
`define LNR_SHIFT_MSB 7

// gain scaling: coring in eighths, sharpening in sixteenths, both capped at code 8
`define LNR_GAIN_MAX 4'h8
`define LNR_CORE_SHIFT 3
`define LNR_SHARP_SHIFT 4

// block geometry in pixels
`define LNR_BLK_SMALL_MASK 4'h7
`define LNR_BLK_LARGE_MASK 4'hf

// luma limits
`define LNR_LUMA_MAX 8'hff

`endif

/* File: lnr_hpf.v */
// selectable high-frequency extraction filter over a five-pixel window
`timescale 1ns/1ns
module lnr_hpf
(
    // window, oldest to newest
    input wire [7:0] i_tap0,
    input wire [7:0] i_tap1,
    input wire [7:0] i_tap2,
    input wire [7:0] i_tap3,
    input wire [7:0] i_tap4,
    // response select
    input wire [2:0] i_sel,
    // signed filter output
    output reg signed [9:0] o_hp
);

    wire signed [11:0] c1;
    wire signed [11:0] c2;
    wire signed [11:0] s1;
    wire signed [11:0] s2;
    reg signed [11:0] t;

    assign c1 = {4'h0, i_tap2};
    assign c2 = {3'h0, i_tap2, 1'b0};
    assign s1 = {4'h0, i_tap1} + {4'h0, i_tap3};
    assign s2 = {4'h0, i_tap0} + {4'h0, i_tap4};

    always @*
    begin
        t = 12'sh000;
        case (i_sel)
            3'h0: t = (c2 - s1) >>> 1;
            3'h1: t = (c2 - s2) >>> 1;
            3'h2: t = (c2 - s1) >>> 2;
            3'h3: t = (c2 - s2) >>> 2;
            3'h4: t = ((c2 <<< 1) - s1 - s2) >>> 2;
            3'h5: t = ((c2 <<< 1) - s1 - s2) >>> 3;
            3'h6: t = c2 - s1;
            // one-sided difference: half of the centre pixel minus the next newer pixel (tap3)
            default: t = (c2 - s1 - (c1 - $signed({4'h0, i_tap1}))) >>> 1;
        endcase
        o_hp = t[9:0];
    end

endmodule

/* File: lnr_luma_noise_reduction.v */
// standard-definition luma noise reduction and sharpening stage
// What this block does
// RULE1 - only luma is processed; chroma passes through unchanged, delay-matched
// RULE2 - extract high-frequency luma and compare its magnitude with threshold each pixel
// RULE3 - coring mode: below threshold, subtract gain times filter output from luma
// RULE4 - sharpening mode: above threshold, add gain times filter output to luma
// RULE5 - bit 4 of third register: 0 coring, 1 sharpening
// RULE6 - low nibble of first register is the border gain at block transitions
// RULE7 - high nibble of first register is the gain inside blocks
// RULE8 - coring gain codes are zero to one in eighths
// RULE9 - sharpening gain codes are zero to one half in sixteenths
// RULE10 - threshold is six-bit magnitude in low bits of second register
// RULE11 - bit 6 of second register: border four pixels wide, else two
// RULE12 - bit 7 of second register: 16x16 blocks, else 8x8
// RULE13 - block counting in pixels, each pixel two 27 MHz cycles
// RULE14 - low three bits of third register pick the extraction filter response
// RULE15 - high nibble of third register shifts block grid 0 to 15 pixels
// RULE16 - shift moves data against fixed gain positions to hit true edges
// RULE17 - each selectable response is a fixed high-frequency extraction filter
// RULE18 - counters restart at each line and field; result clipped to 8 bits
`timescale 1ns/1ns
`include "lnr_regs.vh"
module lnr_luma_noise_reduction
(
    // clock, reset, enable
    input wire i_clk,
    input wire i_rst_n,
    input wire i_ce,
    // register port
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    output wire [7:0] o_reg_rdata,
    // pixel input
    input wire i_pix_valid,
    input wire i_line_start,
    input wire i_field_start,
    input wire [7:0] i_luma,
    input wire [7:0] i_chroma,
    // pixel output
    output wire o_pix_valid,
    output wire [7:0] o_luma,
    output wire [7:0] o_chroma
);

    reg [7:0] gains_ff;
    reg [7:0] thr_blk_ff;
    reg [7:0] filt_mode_ff;
    reg [7:0] rdata_ff;

    reg [3:0] hcnt_ff;
    reg [3:0] vcnt_ff;
    reg [7:0] ywin_ff [0:4];
    reg [7:0] cwin_ff [0:2];
    reg [2:0] bwin_ff;

    reg out_valid_ff;
    reg [7:0] out_luma_ff;
    reg [7:0] out_chroma_ff;

    wire [3:0] gain_border;
    wire [3:0] gain_data;
    wire [5:0] noise_level_limit;
    wire border_wide;
    wire block_large;
    wire [2:0] extract_filter_sel;
    wire sharpen_boost_mode;
    wire [3:0] tile_shift;

    assign gain_border = gains_ff[`LNR_BORDER_GAIN_MSB:`LNR_BORDER_GAIN_LSB];
    assign gain_data = gains_ff[`LNR_DATA_GAIN_MSB:`LNR_DATA_GAIN_LSB];
    assign noise_level_limit = thr_blk_ff[`LNR_LIMIT_MSB:`LNR_LIMIT_LSB];
    assign border_wide = thr_blk_ff[`LNR_BORDER_WIDE_BIT];
    assign block_large = thr_blk_ff[`LNR_BLOCK_LARGE_BIT];
    assign extract_filter_sel = filt_mode_ff[`LNR_FILT_SEL_MSB:`LNR_FILT_SEL_LSB];
    assign sharpen_boost_mode = filt_mode_ff[`LNR_MODE_BIT];
    assign tile_shift = filt_mode_ff[`LNR_SHIFT_MSB:`LNR_SHIFT_LSB];

    // register writes and reads
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            gains_ff <= `LNR_RST_CORING_GAINS;
            thr_blk_ff <= `LNR_RST_THRESH_BLOCK;
            filt_mode_ff <= `LNR_RST_FILT_MODE;
            rdata_ff <= 8'h00;
        end
        else if (i_ce)
        begin
            if (i_reg_wr && i_reg_addr == `LNR_OFS_CORING_GAINS)
                gains_ff <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == `LNR_OFS_THRESH_BLOCK)
                thr_blk_ff <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == `LNR_OFS_FILT_MODE)
                filt_mode_ff <= i_reg_wdata;
            if (i_reg_rd)
            begin
                case (i_reg_addr)
                    `LNR_OFS_CORING_GAINS: rdata_ff <= gains_ff;
                    `LNR_OFS_THRESH_BLOCK: rdata_ff <= thr_blk_ff;
                    `LNR_OFS_FILT_MODE: rdata_ff <= filt_mode_ff;
                    default: rdata_ff <= 8'h00;
                endcase
            end
        end
    end

    assign o_reg_rdata = rdata_ff;

    // block grid position of the incoming pixel
    wire [3:0] blk_mask;
    wire [3:0] hpos;
    wire [3:0] vpos;
    wire [3:0] hcur;
    wire [3:0] vcur;
    wire h_edge;
    wire v_edge;
    wire in_border;

    // RULE12 block size
    assign blk_mask = block_large ? `LNR_BLK_LARGE_MASK : `LNR_BLK_SMALL_MASK;
    // RULE18 restart before shift
    assign hcur = i_line_start ? 4'h0 : hcnt_ff;
    assign vcur = i_field_start ? 4'h0 : (i_line_start ? vcnt_ff + 4'h1 : vcnt_ff);
    // RULE15 grid shift
    // RULE16 data moves against fixed gain positions
    assign hpos = (hcur + tile_shift) & blk_mask;
    assign vpos = vcur & blk_mask;
    // RULE11 border width
    assign h_edge = border_wide ?
        (hpos < 4'h2 || hpos > blk_mask - 4'h2) : (hpos == 4'h0 || hpos == blk_mask);
    assign v_edge = border_wide ?
        (vpos < 4'h2 || vpos > blk_mask - 4'h2) : (vpos == 4'h0 || vpos == blk_mask);
    assign in_border = h_edge | v_edge;

    // RULE13 one count per pixel strobe
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            hcnt_ff <= 4'h0;
            vcnt_ff <= 4'h0;
        end
        else if (i_ce)
        begin
            if (i_field_start)
                vcnt_ff <= 4'h0;
            else if (i_line_start)
                vcnt_ff <= vcnt_ff + 4'h1;
            if (i_pix_valid)
                hcnt_ff <= hcur + 4'h1;
            else if (i_line_start)
                hcnt_ff <= 4'h0;
        end
    end

    // pixel windows: luma five deep, chroma and border flag matched to the centre
    integer k;
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            for (k = 0; k < 5; k = k + 1)
                ywin_ff[k] <= 8'h00;
            for (k = 0; k < 3; k = k + 1)
                cwin_ff[k] <= 8'h00;
            bwin_ff <= 3'h0;
        end
        else if (i_ce && i_pix_valid)
        begin
            ywin_ff[0] <= i_luma;
            for (k = 1; k < 5; k = k + 1)
                ywin_ff[k] <= ywin_ff[k - 1];
            // RULE1 chroma untouched
            cwin_ff[0] <= i_chroma;
            for (k = 1; k < 3; k = k + 1)
                cwin_ff[k] <= cwin_ff[k - 1];
            bwin_ff <= {bwin_ff[1:0], in_border};
        end
    end

    // RULE17 fixed extraction responses
    // RULE14 response select
    wire signed [9:0] hp;
    lnr_hpf u_hpf
    (
        .i_tap0(ywin_ff[4]),
        .i_tap1(ywin_ff[3]),
        .i_tap2(ywin_ff[2]),
        .i_tap3(ywin_ff[1]),
        .i_tap4(ywin_ff[0]),
        .i_sel(extract_filter_sel),
        .o_hp(hp)
    );

    // magnitude test and gain
    wire [9:0] hp_mag;
    wire below;
    wire above;
    wire [3:0] gain_raw;
    wire [3:0] gain;
    wire signed [14:0] prod;
    wire signed [14:0] scaled;
    wire signed [10:0] centre;
    reg signed [10:0] nxt_sum;
    reg [7:0] nxt_luma;

    // RULE2 magnitude compare
    assign hp_mag = hp[9] ? 10'h000 - hp : hp;
    assign below = hp_mag < {4'h0, noise_level_limit};
    // RULE10 six-bit limit
    assign above = hp_mag > {4'h0, noise_level_limit};
    // RULE6 border gain
    // RULE7 inner gain
    assign gain_raw = bwin_ff[2] ? gain_border : gain_data;
    // RULE8 eighths up to one
    // RULE9 sixteenths up to one half
    assign gain = (gain_raw > `LNR_GAIN_MAX) ? `LNR_GAIN_MAX : gain_raw;
    assign prod = hp * $signed({1'b0, gain});
    assign scaled = sharpen_boost_mode ? (prod >>> `LNR_SHARP_SHIFT) :
        (prod >>> `LNR_CORE_SHIFT);
    assign centre = {3'h0, ywin_ff[2]};

    always @*
    begin
        nxt_sum = centre;
        // RULE5 mode select
        if (sharpen_boost_mode)
        begin
            // RULE4 add boost
            if (above)
                nxt_sum = centre + scaled[10:0];
        end
        else
        begin
            // RULE3 subtract noise
            if (below)
                nxt_sum = centre - scaled[10:0];
        end
        // RULE18 clip to 8 bits
        if (nxt_sum < 11'sh000)
            nxt_luma = 8'h00;
        else if (nxt_sum > $signed({3'h0, `LNR_LUMA_MAX}))
            nxt_luma = `LNR_LUMA_MAX;
        else
            nxt_luma = nxt_sum[7:0];
    end

    // output stage
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            out_valid_ff <= 1'b0;
            out_luma_ff <= 8'h00;
            out_chroma_ff <= 8'h00;
        end
        else if (i_ce)
        begin
            out_valid_ff <= i_pix_valid;
            if (i_pix_valid)
            begin
                out_luma_ff <= nxt_luma;
                // RULE1 chroma passes through
                out_chroma_ff <= cwin_ff[2];
            end
        end
    end

    assign o_pix_valid = out_valid_ff;
    assign o_luma = out_luma_ff;
    assign o_chroma = out_chroma_ff;

endmodule

/* File: lnr_properties.sv */
// port assertions for the luma noise reducer
`timescale 1ns/1ns
module lnr_properties
(
    // clock, reset, enable
    input wire i_clk,
    input wire i_rst_n,
    input wire i_ce,
    // register port
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    // pixels
    input wire i_pix_valid,
    input wire [7:0] i_luma,
    input wire [7:0] i_chroma,
    input wire o_pix_valid,
    input wire [7:0] o_luma,
    input wire [7:0] o_chroma
);
reg [7:0] r3_ff, r4_ff, r5_ff, c1_ff, c2_ff, c3_ff, c4_ff, l1_ff, l2_ff, l3_ff, l4_ff;
reg [2:0] n_ff;
wire [7:0] rd_exp = (i_reg_addr == 8'ha3) ? r3_ff : (i_reg_addr == 8'ha4) ? r4_ff :
    (i_reg_addr == 8'ha5) ? r5_ff : 8'h00;
// zero gain, or coring with zero threshold, leaves luma untouched
wire same = (r3_ff == 8'h00) || (!r5_ff[4] && r4_ff[5:0] == 6'h00);
always @(posedge i_clk)
begin
    if (!i_rst_n)
    begin
        {r3_ff, r4_ff, r5_ff} <= 24'h000000;
        {c1_ff, c2_ff, c3_ff, c4_ff, l1_ff, l2_ff, l3_ff, l4_ff} <= 64'h0;
        n_ff <= 3'h0;
    end
    else if (i_ce)
    begin
        if (i_reg_wr && i_reg_addr == 8'ha3)
            r3_ff <= i_reg_wdata;
        if (i_reg_wr && i_reg_addr == 8'ha4)
            r4_ff <= i_reg_wdata;
        if (i_reg_wr && i_reg_addr == 8'ha5)
            r5_ff <= i_reg_wdata;
        if (i_pix_valid)
        begin
            // the output pulse after input pulse n carries pixel n-3
            {c4_ff, c3_ff, c2_ff, c1_ff} <= {c3_ff, c2_ff, c1_ff, i_chroma};
            {l4_ff, l3_ff, l2_ff, l1_ff} <= {l3_ff, l2_ff, l1_ff, i_luma};
            if (n_ff != 3'h4)
                n_ff <= n_ff + 3'h1;
        end
    end
end
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_rst_n);
property p_out_follows;
    i_ce && i_pix_valid |=> o_pix_valid;
endproperty
a_out_follows: assert property (p_out_follows) else $error("missing output pixel");
property p_out_needs_in;
    i_ce && !i_pix_valid |=> !o_pix_valid;
endproperty
a_out_needs_in: assert property (p_out_needs_in) else $error("spurious output");
property p_out_hold;
    !o_pix_valid |-> $stable(o_luma) && $stable(o_chroma);
endproperty
a_out_hold: assert property (p_out_hold) else $error("output data moved");
property p_chroma_pass;
    o_pix_valid && n_ff == 3'h4 |-> o_chroma == c4_ff;
endproperty
a_chroma_pass: assert property (p_chroma_pass) else $error("chroma altered");
property p_identity;
    o_pix_valid && n_ff == 3'h4 && $past(same) |-> o_luma == l4_ff;
endproperty
a_identity: assert property (p_identity) else $error("luma altered");
property p_rd_value;
    i_ce && i_reg_rd |=> o_reg_rdata == $past(rd_exp);
endproperty
a_rd_value: assert property (p_rd_value) else $error("bad read data");
property p_rd_hold;
    !i_reg_rd |=> $stable(o_reg_rdata);
endproperty
a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
property p_unmapped;
    i_reg_rd && (i_reg_addr < 8'ha3 || i_reg_addr > 8'ha5) |=> o_reg_rdata == 8'h00;
endproperty
a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule
bind lnr_luma_noise_reduction lnr_properties lnr_properties_i
(
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .i_pix_valid(i_pix_valid),
    .i_luma(i_luma),
    .i_chroma(i_chroma),
    .o_pix_valid(o_pix_valid),
    .o_luma(o_luma),
    .o_chroma(o_chroma)
);

/* File: lnr_pix_src.sv */
// upstream pixel source model
`timescale 1ns/1ns
module lnr_pix_src
(
    // clock
    input wire i_clk,
    // pixel stream
    output reg o_pix_valid,
    output reg o_line_start,
    output reg o_field_start,
    output reg [7:0] o_luma,
    output reg [7:0] o_chroma
);
integer k = 0;
integer j = 0;
integer l = 0;
initial
begin
    {o_pix_valid, o_line_start, o_field_start} = 3'h0;
    {o_luma, o_chroma} = 16'h0;
end
// one field of four lines of sixteen pixels, alternating luma
task frame(input [7:0] base, input [7:0] amp);
begin
    for (l = 0; l < 4; l = l + 1)
    begin
        for (j = 0; j < 16; j = j + 1)
        begin
            @(posedge i_clk) #1;
            o_line_start = (j == 0);
            o_field_start = (j == 0 && l == 0);
            o_pix_valid = 1'b1;
            o_luma = k[0] ? base + amp : base;
            o_chroma = k[7:0];
            @(posedge i_clk) #1;
            // line and field marks stand only with their own pixel
            {o_pix_valid, o_line_start, o_field_start} = 3'h0;
            o_luma = ~o_luma;
            o_chroma = ~o_chroma;
            k = k + 1;
        end
    end
end
endtask
endmodule

/* File: lnr_luma_noise_reduction_tb.sv */
// self-checking bench for the luma noise reducer
`timescale 1ns/1ns
`include "lnr_regs.vh"
`define CHK(a, b) begin num_checks = num_checks + 1; if ((a) !== (b)) begin fails = fails + 1; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module lnr_luma_noise_reduction_tb;
reg i_clk = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, ce = 1'b1;
reg [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, r3 = 8'h00, r4 = 8'h00, r5 = 8'h00;
wire [7:0] o_reg_rdata, luma, chroma, o_luma, o_chroma;
wire pv, ls, fs, o_pix_valid;
integer fails = 0, num_checks = 0, ko = 0, ki = 0, i;
integer yv [0:2047];
// border flag of each pixel, fixed by the geometry in force when it entered
reg bf [0:2047];
reg [7:0] cr [0:2047];
lnr_pix_src lnr_pix_src_i (.i_clk(i_clk), .o_pix_valid(pv), .o_line_start(ls),
    .o_field_start(fs), .o_luma(luma), .o_chroma(chroma));
lnr_luma_noise_reduction lnr_luma_noise_reduction_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ce(ce), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_pix_valid(pv),
    .i_line_start(ls), .i_field_start(fs), .i_luma(luma), .i_chroma(chroma),
    .o_pix_valid(o_pix_valid), .o_luma(o_luma), .o_chroma(o_chroma));
always #4 i_clk = ~i_clk;
function bflag(input integer h0, input integer v0);
    integer sz, h, v;
    begin
        sz = r4[7] ? 16 : 8;
        h = (h0 + r5[7:4]) % sz;
        v = v0 % sz;
        bflag = r4[6] ? (h < 2 || h > sz - 3 || v < 2 || v > sz - 3) :
            (h == 0 || h == sz - 1 || v == 0 || v == sz - 1);
    end
endfunction
function [7:0] exp_y(input integer p);
    integer c, hp, g, y;
    begin
        c = yv[p];
        case (r5[2:0])
            3'h0: hp = (2 * c - yv[p - 1] - yv[p + 1]) >>> 1;
            3'h1: hp = (2 * c - yv[p - 2] - yv[p + 2]) >>> 1;
            3'h2: hp = (2 * c - yv[p - 1] - yv[p + 1]) >>> 2;
            3'h3: hp = (2 * c - yv[p - 2] - yv[p + 2]) >>> 2;
            3'h4: hp = (4 * c - yv[p - 1] - yv[p + 1] - yv[p - 2] - yv[p + 2]) >>> 2;
            3'h5: hp = (4 * c - yv[p - 1] - yv[p + 1] - yv[p - 2] - yv[p + 2]) >>> 3;
            3'h6: hp = 2 * c - yv[p - 1] - yv[p + 1];
            default: hp = (c - yv[p + 1]) >>> 1;
        endcase
        g = bf[p] ? r3[3:0] : r3[7:4];
        g = (g > 8) ? 8 : g;
        y = c;
        if (!r5[4] && (hp < 0 ? -hp : hp) < r4[5:0])
            y = c - ((hp * g) >>> 3);
        if (r5[4] && (hp < 0 ? -hp : hp) > r4[5:0])
            y = c + ((hp * g) >>> 4);
        exp_y = (y < 0) ? 8'h00 : (y > 255) ? 8'hff : y;
    end
endfunction
// output pixel n pairs with input pixel n-3
always @(posedge i_clk)
begin
    if (o_pix_valid && ko >= 5)
    begin
        `CHK(o_luma, exp_y(ko - 3))
        `CHK(o_chroma, cr[ko - 3])
    end
    if (o_pix_valid)
        ko = ko + 1;
    if (pv)
    begin
        yv[ki] = luma;
        cr[ki] = chroma;
        bf[ki] = bflag(lnr_pix_src_i.j, lnr_pix_src_i.l);
        ki = ki + 1;
    end
end
task wr(input [7:0] a, input [7:0] d);
begin
    @(posedge i_clk) #1;
    {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
    @(posedge i_clk) #1;
    i_reg_wr = 1'b0;
    r3 = (a == 8'ha3) ? d : r3;
    r4 = (a == 8'ha4) ? d : r4;
    r5 = (a == 8'ha5) ? d : r5;
end
endtask
task rd(input [7:0] a, input [7:0] e);
begin
    @(posedge i_clk) #1;
    {i_reg_rd, i_reg_addr} = {1'b1, a};
    @(posedge i_clk) #1;
    i_reg_rd = 1'b0;
    `CHK(o_reg_rdata, e)
end
endtask
task run(input [7:0] g, input [7:0] t, input [7:0] m, input [7:0] b, input [7:0] a);
begin
    wr(`LNR_OFS_CORING_GAINS, g);
    wr(`LNR_OFS_THRESH_BLOCK, t);
    wr(`LNR_OFS_FILT_MODE, m);
    lnr_pix_src_i.frame(b, a);
    @(posedge i_clk) #1;
    `CHK(ko, ki)
end
endtask
task t_regs;
begin
    rd(8'ha3, 8'h00);
    rd(8'ha4, 8'h00);
    rd(8'ha5, 8'h00);
    wr(8'ha3, 8'h5c);
    wr(8'ha4, 8'hc7);
    wr(8'ha5, 8'h96);
    wr(8'ha6, 8'hff);
    rd(8'ha3, 8'h5c);
    rd(8'ha4, 8'hc7);
    rd(8'ha5, 8'h96);
    rd(8'ha6, 8'h00);
end
endtask
task t_core;
begin
    run(8'h00, 8'h3f, 8'h06, 8'h64, 8'h0a);
    run(8'h88, 8'h15, 8'h06, 8'h64, 8'h0a);
    run(8'h44, 8'h14, 8'h06, 8'h64, 8'h0a);
    run(8'h8c, 8'h3f, 8'h06, 8'h64, 8'h09);
end
endtask
task t_sharp;
begin
    run(8'h8f, 8'h13, 8'h16, 8'h64, 8'h0a);
    run(8'h4f, 8'h14, 8'h16, 8'h64, 8'h0a);
    run(8'h88, 8'h3f, 8'h16, 8'h00, 8'hfa);
end
endtask
task t_border;
begin
    for (i = 0; i < 4; i = i + 1)
        run(8'h08, {i[1:0], 6'h3f}, i[0] ? 8'he6 : 8'h26, 8'h64, 8'h0a);
end
endtask
task t_sel;
begin
    for (i = 0; i < 8; i = i + 1)
        run(8'h88, 8'h3f, {5'h00, i[2:0]}, 8'h64, 8'h0a);
end
endtask
// a write while the clock enable is low must not land
task t_ce;
begin
    @(posedge i_clk) #1;
    {ce, i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b0, 1'b1, 8'ha3, 8'h11};
    @(posedge i_clk) #1;
    {ce, i_reg_wr} = 2'b10;
    rd(8'ha3, r3);
end
endtask
task finish_test;
begin
    if (fails == 0 && num_checks > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
end
endtask
initial
begin
    #100000;
    fails = fails + 1;
    finish_test;
end
initial
begin
    repeat (3) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    t_regs;
    t_ce;
    t_core;
    t_sharp;
    t_border;
    t_sel;
    finish_test;
end
endmodule
